// >>> shared/imsbr_pkg.sv
/*
  Shared constants and types for the I2C multiplexer stuck-bus recovery block.
  Assumes a 50 MHz system clock and a 160 ns link clock for the recovery pulse engine.
*/
package imsbr_pkg;

  // Channel count and system clock rate
  localparam int NCH = 4;
  localparam int CLK_FREQ_KHZ = 50000;

  // Stuck-bus window: 45 ms counted in system clock cycles
  localparam int STUCK_TIME_MS = 45;
  localparam int STUCK_CYCLES = STUCK_TIME_MS * CLK_FREQ_KHZ;
  localparam int STUCK_CNT_W = 32;

  // Link clock period and standard-mode phase minima, rounded up to whole link cycles
  localparam int LINK_PERIOD_NS = 160;
  localparam int SCL_LOW_MIN_NS = 4700;
  localparam int SCL_HIGH_MIN_NS = 4000;
  localparam int SCL_LOW_CYC = (SCL_LOW_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int SCL_HIGH_CYC = (SCL_HIGH_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int PHASE_W = 6;

  // Recovery pulse limit
  localparam int REC_PULSES_MAX = 16;
  localparam int REC_CNT_W = 5;

  // Holdoff after our own upstream drive releases, covers the synchroniser latency
  localparam int HOLD_W = 3;

  // Reset values
  localparam logic FAULT_RST = 1'b1;
  localparam logic CONNECTED_RST = 1'b1;

  // Three-level accelerator pin, encoded by the pad into two bits
  typedef enum logic [1:0] {
    IMSBR_ACC_OPEN = 2'h0,
    IMSBR_ACC_GROUND = 2'h1,
    IMSBR_ACC_HIGH = 2'h2
  } imsbr_acc_t;

  // One-hot recovery engine states
  typedef enum logic [5:0] {
    REC_IDLE = 6'h01,
    REC_LOW = 6'h02,
    REC_HIGH = 6'h04,
    REC_STOP_LOW = 6'h08,
    REC_STOP_SCLH = 6'h10,
    REC_STOP_SDAH = 6'h20
  } imsbr_rec_t;

  // Upstream pin pair
  typedef struct packed {
    logic scl;
    logic sda;
  } imsbr_up_t;

  // Downstream pin groups, one bit per channel
  typedef struct packed {
    logic [NCH-1:0] scl;
    logic [NCH-1:0] sda;
  } imsbr_dn_t;

endpackage

// >>> verilog/imsbr_sync.sv
/*
  Two-flop level synchroniser, one pair of flops per bit.
  Assumes inputs are quasi-static levels; multi-bit values must be stable when sampled.
*/
`timescale 1ns/10ps
module imsbr_sync #(
  parameter int W = 1
) (
  // Clock and reset of the receiving domain
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  genvar b;
  for (b = 0; b < W; b = b + 1) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta[b] <= 1'b1;
        q_o[b] <= 1'b1;
      end else begin
        meta[b] <= d_i[b];
        q_o[b] <= meta[b];
      end
    end
  end

endmodule // imsbr_sync

// >>> verilog/imsbr_mux.sv
/*
  Four-channel I2C multiplexer core: channel select, buffered pass-through,
  45 ms stuck-bus watchdog, fault flag, automatic disconnect and recovery pulses.
  Assumes open-drain pads outside (pull-ups external), a free-running link clock
  for the recovery engine, and a pad that encodes the three-level accelerator pin.
*/
`timescale 1ns/10ps
module imsbr_mux #(
  parameter int STUCK_CYCLES_P = imsbr_pkg::STUCK_CYCLES
) (
  // System clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Link clock for the recovery pulse engine
  input wire logic link_clk_i,
  // Configuration pins
  input wire logic [imsbr_pkg::NCH-1:0] channel_select_i,
  input wire logic auto_disconnect_sel_i,
  input wire imsbr_pkg::imsbr_acc_t accelerator_mode_sel_i,
  // Upstream open-drain pins
  input wire imsbr_pkg::imsbr_up_t up_i,
  output imsbr_pkg::imsbr_up_t up_o,
  output imsbr_pkg::imsbr_up_t up_oe_o,
  // Downstream open-drain pins
  input wire imsbr_pkg::imsbr_dn_t dn_i,
  output imsbr_pkg::imsbr_dn_t dn_o,
  output imsbr_pkg::imsbr_dn_t dn_oe_o,
  // Status and accelerator controls
  output logic stuck_alarm_n_o,
  output logic connected_o,
  output logic rise_accelerator_source_en_o,
  output logic rise_accelerator_slew_en_o
);
  import imsbr_pkg::*;

  // Synchronised pins in the system domain
  logic [NCH-1:0] sel_s;
  logic disc_s;
  logic [1:0] acc_s;
  imsbr_up_t up_s;
  imsbr_dn_t dn_s;
  logic [NCH-1:0] sel_d;

  // Control state
  logic connected;
  logic fault_n;
  logic all_low_seen;
  logic [STUCK_CNT_W-1:0] stuck_cnt;
  logic [NCH-1:0] rec_mask;
  logic start_tgl;
  logic done_seen;
  logic done_s;
  logic recovering;

  // Pass-through drive state
  imsbr_up_t up_drv;
  imsbr_dn_t dn_drv;
  logic [HOLD_W-1:0] scl_hold;
  logic [HOLD_W-1:0] sda_hold;

  // Link domain
  logic link_rst_m;
  logic link_rst;
  logic start_s;
  logic start_seen;
  logic [NCH-1:0] mask_l;
  logic [NCH-1:0] dn_sda_l;
  imsbr_rec_t rec_state;
  logic [PHASE_W-1:0] phase_cnt;
  logic [REC_CNT_W-1:0] pulse_cnt;
  logic rec_scl_low;
  logic rec_sda_low;
  logic done_tgl;

  // Derived terms
  logic any_sel;
  logic bus_idle_high;
  logic sel_rise;
  logic timeout;
  logic data_released;
  logic [NCH-1:0] dn_scl_low_ext;
  logic [NCH-1:0] dn_sda_low_ext;

  // Pin synchronisers for the system domain
  imsbr_sync #(.W(NCH + 3 + 2 + 2 * NCH)) u_sync_pins (
    .clk_i(clk_i),
    .rst_i(sys_rst_i),
    .d_i({channel_select_i, auto_disconnect_sel_i, accelerator_mode_sel_i, up_i, dn_i}),
    .q_o({sel_s, disc_s, acc_s, up_s, dn_s})
  );

  // Recovery-done toggle back from the link domain
  imsbr_sync #(.W(1)) u_sync_done (
    .clk_i(clk_i),
    .rst_i(sys_rst_i),
    .d_i(done_tgl),
    .q_o(done_s)
  );

  // Reset carried into the link domain; no reset on its own flops
  always_ff @(posedge link_clk_i) begin
    link_rst_m <= sys_rst_i;
    link_rst <= link_rst_m;
  end

  // Start toggle, channel mask and downstream data into the link domain
  imsbr_sync #(.W(1 + 2 * NCH)) u_sync_link (
    .clk_i(link_clk_i),
    .rst_i(link_rst),
    .d_i({start_tgl, rec_mask, dn_i.sda}),
    .q_o({start_s, mask_l, dn_sda_l})
  );

  // idle-high seen on every selected bus
  assign any_sel = |sel_s;
  assign bus_idle_high = any_sel && ((sel_s & dn_s.scl & dn_s.sda) == sel_s);
  assign sel_rise = |(sel_s & ~sel_d);
  assign timeout = stuck_cnt >= STUCK_CNT_W'(STUCK_CYCLES_P - 1);

  // Previous selects for edge detection
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sel_d <= '0;
    end else begin
      sel_d <= sel_s;
    end
  end

  // stuck timer restarts on idle-high or selection change
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stuck_cnt <= '0;
    end else if (!any_sel || bus_idle_high || sel_s != sel_d || !fault_n) begin
      stuck_cnt <= '0;
    end else if (!timeout) begin
      stuck_cnt <= stuck_cnt + STUCK_CNT_W'(1);
    end
  end

  // Remembers an all-deselected moment after a fault
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      all_low_seen <= 1'b0;
    end else if (fault_n) begin
      all_low_seen <= 1'b0;
    end else if (!any_sel) begin
      all_low_seen <= 1'b1;
    end
  end

  // Stuck alarm: timeout sets it; the set wins over the clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fault_n <= FAULT_RST;
    end else if (timeout && fault_n && any_sel) begin
      fault_n <= 1'b0;
    end else if (all_low_seen && sel_rise) begin
      fault_n <= 1'b1;
    end
  end

  // Connection state between the two sides
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      connected <= CONNECTED_RST;
    end else if (timeout && fault_n && any_sel && disc_s) begin
      connected <= 1'b0;
    end else if (!connected && all_low_seen && sel_rise) begin
      connected <= 1'b1;
    end
  end

  // Recovery launch; the mask is loaded in the same cycle as the toggle and then held while recovery runs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      start_tgl <= 1'b1; // Matches the synchroniser reset level, so no false start
      rec_mask <= '0;
      recovering <= 1'b0;
      done_seen <= 1'b1;
    end else begin
      done_seen <= done_s;
      if (timeout && fault_n && any_sel && disc_s && !recovering) begin
        // start recovery clocks; none when auto disconnect low
        rec_mask <= sel_s;
        start_tgl <= ~start_tgl;
        recovering <= 1'b1;
      end else if (done_s != done_seen) begin
        recovering <= 1'b0;
      end
    end
  end

  // Releasing our own drive leaves the line looking low for a few cycles
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_hold <= '0;
      sda_hold <= '0;
    end else begin
      scl_hold <= {scl_hold[HOLD_W-2:0], up_drv.scl};
      sda_hold <= {sda_hold[HOLD_W-2:0], up_drv.sda};
    end
  end

  // Low on a selected downstream line not caused by our own drive
  assign dn_scl_low_ext = sel_s & ~dn_s.scl & ~dn_drv.scl;
  assign dn_sda_low_ext = sel_s & ~dn_s.sda & ~dn_drv.sda;

  // pass-through on every selected channel, registered
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !connected) begin
      up_drv <= '0;
      dn_drv <= '0;
    end else begin
      up_drv.scl <= (|dn_scl_low_ext) && !(|dn_drv.scl);
      up_drv.sda <= (|dn_sda_low_ext) && !(|dn_drv.sda);
      // each channel gated by its own select
      dn_drv.scl <= (!up_s.scl && !up_drv.scl && !(|scl_hold)) ? sel_s : '0;
      dn_drv.sda <= (!up_s.sda && !up_drv.sda && !(|sda_hold)) ? sel_s : '0;
    end
  end

  // Link domain: start edge detector on the synchronised toggle
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      start_seen <= 1'b1; // Same level as the synchronised toggle after reset
    end else begin
      start_seen <= start_s;
    end
  end

  // data counted released when every recovering channel reads high
  assign data_released = (dn_sda_l & mask_l) == mask_l;

  // Recovery pulse engine
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      rec_state <= REC_IDLE;
      phase_cnt <= '0;
      pulse_cnt <= '0;
      done_tgl <= 1'b1;
    end else begin
      case (rec_state)
        REC_IDLE: begin
          phase_cnt <= '0;
          pulse_cnt <= '0;
          if (start_s != start_seen) begin
            rec_state <= REC_LOW;
          end
        end
        REC_LOW: begin
          // low phase at least the minimum
          if (phase_cnt == PHASE_W'(SCL_LOW_CYC - 1)) begin
            phase_cnt <= '0;
            rec_state <= REC_HIGH;
          end else begin
            phase_cnt <= phase_cnt + PHASE_W'(1);
          end
        end
        REC_HIGH: begin
          // high phase at least the minimum
          if (phase_cnt == PHASE_W'(SCL_HIGH_CYC - 1)) begin
            phase_cnt <= '0;
            // stop on data high or sixteenth pulse
            if (data_released || pulse_cnt == REC_CNT_W'(REC_PULSES_MAX - 1)) begin
              rec_state <= REC_STOP_LOW;
            end else begin
              pulse_cnt <= pulse_cnt + REC_CNT_W'(1);
              rec_state <= REC_LOW;
            end
          end else begin
            phase_cnt <= phase_cnt + PHASE_W'(1);
          end
        end
        REC_STOP_LOW: begin
          // clock and data low ahead of stop
          if (phase_cnt == PHASE_W'(SCL_LOW_CYC - 1)) begin
            phase_cnt <= '0;
            rec_state <= REC_STOP_SCLH;
          end else begin
            phase_cnt <= phase_cnt + PHASE_W'(1);
          end
        end
        REC_STOP_SCLH: begin
          // clock high, then data rises for stop
          if (phase_cnt == PHASE_W'(SCL_HIGH_CYC - 1)) begin
            phase_cnt <= '0;
            rec_state <= REC_STOP_SDAH;
          end else begin
            phase_cnt <= phase_cnt + PHASE_W'(1);
          end
        end
        REC_STOP_SDAH: begin
          // Bus free time before handing back
          if (phase_cnt == PHASE_W'(SCL_HIGH_CYC - 1)) begin
            phase_cnt <= '0;
            done_tgl <= ~done_tgl;
            rec_state <= REC_IDLE;
          end else begin
            phase_cnt <= phase_cnt + PHASE_W'(1);
          end
        end
        default: begin
          rec_state <= REC_IDLE;
        end
      endcase
    end
  end

  // Recovery line drive, registered in the link domain
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      rec_scl_low <= 1'b0;
      rec_sda_low <= 1'b0;
    end else begin
      rec_scl_low <= (rec_state == REC_LOW) || (rec_state == REC_STOP_LOW);
      rec_sda_low <= (rec_state == REC_STOP_LOW) || (rec_state == REC_STOP_SCLH);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rise_accelerator_source_en_o <= 1'b0;
      rise_accelerator_slew_en_o <= 1'b0;
    end else begin
      rise_accelerator_source_en_o <= acc_s == IMSBR_ACC_OPEN;
      rise_accelerator_slew_en_o <= acc_s == IMSBR_ACC_GROUND;
    end
  end

  // Pin outputs; open drain so data is always low and enables carry the drive.
  // The mask is stable while recovery runs, so mixing domains here is only an OR of flops.
  assign up_o = '0;
  assign dn_o = '0;
  assign up_oe_o = up_drv;
  assign dn_oe_o.scl = dn_drv.scl | (rec_scl_low ? rec_mask : '0);
  assign dn_oe_o.sda = dn_drv.sda | (rec_sda_low ? rec_mask : '0);
  assign stuck_alarm_n_o = fault_n;
  assign connected_o = connected;

endmodule // imsbr_mux

// >>> tb/imsbr_props.sv
/* Assertion checker for imsbr_mux, bound to every instance.
   Assumes pins stay still while a check spans them. */
`timescale 1ns/10ps
module imsbr_props #(
  parameter int STUCK_CYCLES_P = 200
) (
  // Clocks and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_i,
  // Pins
  input wire logic [imsbr_pkg::NCH-1:0] channel_select_i,
  input wire logic auto_disconnect_sel_i,
  input wire imsbr_pkg::imsbr_acc_t accelerator_mode_sel_i,
  input wire imsbr_pkg::imsbr_up_t up_i,
  input wire imsbr_pkg::imsbr_up_t up_oe_o,
  input wire imsbr_pkg::imsbr_dn_t dn_i,
  input wire imsbr_pkg::imsbr_dn_t dn_oe_o,
  // Status
  input wire logic stuck_alarm_n_o,
  input wire logic connected_o,
  input wire logic rise_accelerator_source_en_o,
  input wire logic rise_accelerator_slew_en_o
);
  import imsbr_pkg::*;
  int hi_cnt;
  int bad_cnt;
  logic [NCH-1:0] sel_q;
  logic zero_seen;
  logic [4:0] rises;
  logic scl_q;
  int low_cnt;
  int high_cnt;

  // Age of the alarm-high spell and of a selected bus never idle
  always_ff @(posedge clk_i) begin
    sel_q <= channel_select_i;
    hi_cnt <= (sys_rst_i || !stuck_alarm_n_o) ? 0 : hi_cnt + 1;
    if (sys_rst_i || !stuck_alarm_n_o || channel_select_i != sel_q || channel_select_i == '0
        || (dn_i.scl & dn_i.sda & channel_select_i) == channel_select_i) begin
      bad_cnt <= 0;
    end else begin
      bad_cnt <= bad_cnt + 1;
    end
  end

  // Selects seen all low while the alarm is down
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || stuck_alarm_n_o) zero_seen <= 1'b0;
    else if (channel_select_i == '0) zero_seen <= 1'b1;
  end

  // Rises of the channel 0 clock drive, one per recovery pulse; the stop adds one more
  always_ff @(posedge link_clk_i) begin
    scl_q <= dn_oe_o.scl[0];
    low_cnt <= (sys_rst_i || !dn_oe_o.scl[0]) ? 0 : low_cnt + 1;
    high_cnt <= (sys_rst_i || dn_oe_o.scl[0]) ? 0 : high_cnt + 1;
    if (sys_rst_i || connected_o) rises <= 5'h00;
    else if (dn_oe_o.scl[0] && !scl_q) rises <= rises + 5'h01;
  end

  sequence acc_held(imsbr_acc_t m);
    (accelerator_mode_sel_i == m) [*4];
  endsequence
  sequence scl_low_span;
    dn_oe_o.scl[0] [*8];
  endsequence

  timeout_min_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(stuck_alarm_n_o) |-> hi_cnt >= STUCK_CYCLES_P) else $error("alarm too early");
  timeout_max_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bad_cnt <= STUCK_CYCLES_P + 16) else $error("alarm too late");
  disc_mode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(stuck_alarm_n_o) |-> connected_o == !auto_disconnect_sel_i)
    else $error("disconnect mode wrong");
  release_seq_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(stuck_alarm_n_o) |-> zero_seen && channel_select_i != '0)
    else $error("alarm released without select sequence");
  conn_rise_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(connected_o) |-> $rose(stuck_alarm_n_o)) else $error("reconnect without release");
  pulse_max_a: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
    rises <= 5'h11) else $error("too many recovery clocks");
  phase_low_a: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
    $rose(dn_oe_o.scl[0]) && !connected_o |-> scl_low_span) else $error("clock low too short");
  low_len_a: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
    $fell(dn_oe_o.scl[0]) && !connected_o |-> low_cnt * LINK_PERIOD_NS >= SCL_LOW_MIN_NS)
    else $error("clock low phase under minimum");
  high_len_a: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
    $rose(dn_oe_o.scl[0]) && !connected_o && rises != 5'h00
    |-> high_cnt * LINK_PERIOD_NS >= SCL_HIGH_MIN_NS) else $error("clock high phase under minimum");
  down_pass_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (connected_o && channel_select_i[0] && !up_i.sda && !up_oe_o.sda) [*8] |-> dn_oe_o.sda[0])
    else $error("low not passed down");
  up_pass_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (connected_o && channel_select_i[0] && !dn_i.sda[0] && !dn_oe_o.sda[0]) [*8]
    |-> up_oe_o.sda) else $error("low not passed up");
  acc_open_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    acc_held(IMSBR_ACC_OPEN) |-> rise_accelerator_source_en_o && !rise_accelerator_slew_en_o)
    else $error("open mode wrong");
  acc_high_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    acc_held(IMSBR_ACC_HIGH) |-> !rise_accelerator_source_en_o && !rise_accelerator_slew_en_o)
    else $error("high mode wrong");
endmodule // imsbr_props

bind imsbr_mux imsbr_props #(.STUCK_CYCLES_P(STUCK_CYCLES_P)) u_props (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i),
  .channel_select_i(channel_select_i), .auto_disconnect_sel_i(auto_disconnect_sel_i),
  .accelerator_mode_sel_i(accelerator_mode_sel_i), .up_i(up_i), .up_oe_o(up_oe_o),
  .dn_i(dn_i), .dn_oe_o(dn_oe_o), .stuck_alarm_n_o(stuck_alarm_n_o),
  .connected_o(connected_o), .rise_accelerator_source_en_o(rise_accelerator_source_en_o),
  .rise_accelerator_slew_en_o(rise_accelerator_slew_en_o));

// >>> tb/imsbr_bus_model.sv
/* Wires around imsbr_mux: pulled-up lines, an upstream master and
   a slave that sticks data low. Assumes the bench commands every low. */
`timescale 1ns/10ps
module imsbr_bus_model (
  // Drives from the multiplexer
  input wire imsbr_pkg::imsbr_up_t up_oe_i,
  input wire imsbr_pkg::imsbr_dn_t dn_oe_i,
  // Commands from the bench
  input wire logic up_sda_low_i,
  input wire logic [imsbr_pkg::NCH-1:0] hold_i,
  input wire logic [4:0] rel_i,
  // Resolved wire levels
  output imsbr_pkg::imsbr_up_t up_o,
  output imsbr_pkg::imsbr_dn_t dn_o
);
  import imsbr_pkg::*;
  logic [4:0] clocks = 5'h00;
  // Wired-AND with pull-ups, so a released line reads high
  assign up_o.scl = ~up_oe_i.scl;
  assign up_o.sda = ~(up_oe_i.sda | up_sda_low_i);
  assign dn_o.scl = ~dn_oe_i.scl;
  assign dn_o.sda = ~(dn_oe_i.sda | (hold_i & {NCH{clocks != rel_i}}));
  always @(posedge dn_o.scl[0] or negedge hold_i[0]) begin
    if (!hold_i[0]) clocks <= 5'h00;
    else if (clocks != rel_i) clocks <= clocks + 5'h01;
  end
endmodule // imsbr_bus_model

// >>> tb/imsbr_mux_tb.sv
/* Self-checking bench for imsbr_mux with a behavioural bus model.
   Assumes a stuck window shortened to 200 clocks. */
`timescale 1ns/10ps
module imsbr_mux_tb;
  import imsbr_pkg::*;
  logic clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [NCH-1:0] sel = '0;
  logic auto_dis = 1'b0;
  imsbr_acc_t acc = IMSBR_ACC_HIGH;
  logic up_low = 1'b0;
  logic [NCH-1:0] hold = '0;
  logic [4:0] rel = 5'h1f;
  imsbr_up_t up_i;
  imsbr_up_t up_oe;
  imsbr_dn_t dn_i;
  imsbr_dn_t dn_oe;
  imsbr_up_t up_pin;
  imsbr_dn_t dn_pin;
  logic alarm_n;
  logic conn;
  logic src_en;
  logic slew_en;
  int errors = 0;
  int cmp_count = 0;
  int falls = 0;
  int stops = 0;

  // Clocks; link offset keeps phases unrelated
  always #10 clk_i = ~clk_i;
  initial #7 forever #80 link_clk_i = ~link_clk_i;

  imsbr_mux #(.STUCK_CYCLES_P(200)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .link_clk_i(link_clk_i), .channel_select_i(sel), .auto_disconnect_sel_i(auto_dis),
    .accelerator_mode_sel_i(acc), .up_i(up_i), .up_o(up_pin), .up_oe_o(up_oe), .dn_i(dn_i),
    .dn_o(dn_pin), .dn_oe_o(dn_oe), .stuck_alarm_n_o(alarm_n), .connected_o(conn),
    .rise_accelerator_source_en_o(src_en), .rise_accelerator_slew_en_o(slew_en));
  imsbr_bus_model bus (.up_oe_i(up_oe), .dn_oe_i(dn_oe), .up_sda_low_i(up_low),
    .hold_i(hold), .rel_i(rel), .up_o(up_i), .dn_o(dn_i));

  // Clock falls and stop edges on channel 0
  always @(negedge dn_i.scl[0]) falls++;
  always @(negedge dn_oe.sda[0]) if (dn_i.scl[0]) stops++;

  task automatic chk_bits(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_cnt(input string what, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wait_alarm(input logic lvl);
    for (int i = 0; i < 400 && alarm_n !== lvl; i++) cyc(1);
  endtask

  task automatic t_reset;
    chk_bits("alarm", 8'h01, alarm_n);
    chk_bits("connected", 8'h01, conn);
    chk_bits("down oe", 8'h00, dn_oe);
    chk_bits("up oe", 8'h00, up_oe);
    chk_bits("up data", 8'h00, up_pin);
    chk_bits("down data", 8'h00, dn_pin);
    $display("test reset done");
  endtask

  task automatic t_accel;
    for (int i = 0; i < 3; i++) begin
      acc = imsbr_acc_t'(i);
      cyc(5);
      chk_bits("accel", {6'h00, acc == IMSBR_ACC_GROUND, acc == IMSBR_ACC_OPEN},
        {6'h00, slew_en, src_en});
    end
    $display("test accel done");
  endtask

  task automatic t_pass;
    sel = 4'h5;
    cyc(4);
    up_low = 1'b1;
    cyc(9);
    chk_bits("down sda oe", 8'h05, dn_oe.sda);
    chk_bits("down scl oe", 8'h00, dn_oe.scl);
    up_low = 1'b0;
    cyc(5);
    chk_bits("down sda oe", 8'h00, dn_oe.sda);
    sel = 4'h2;
    cyc(4);
    up_low = 1'b1;
    cyc(5);
    chk_bits("down sda oe", 8'h02, dn_oe.sda);
    up_low = 1'b0;
    sel = '0;
    cyc(5);
    $display("test pass done");
  endtask

  task automatic t_stuck_auto(input logic [4:0] rel_n);
    auto_dis = 1'b1;
    rel = rel_n;
    sel = 4'h1;
    hold = 4'h1;
    falls = 0;
    stops = 0;
    wait_alarm(1'b0);
    chk_bits("alarm", 8'h00, alarm_n);
    chk_bits("connected", 8'h00, conn);
    cyc(9000);
    chk_cnt("clocks", ((rel_n < REC_PULSES_MAX) ? rel_n : REC_PULSES_MAX) + 1, falls);
    chk_cnt("stops", 1, stops);
    chk_bits("alarm held", 8'h00, alarm_n);
    sel = '0;
    cyc(6);
    chk_bits("connected", 8'h00, conn);
    sel = 4'h1;
    cyc(6);
    chk_bits("connected", 8'h01, conn);
    chk_bits("alarm", 8'h01, alarm_n);
    // Slave drops data again after reconnection
    hold = '0;
    cyc(2);
    hold = 4'h1;
    cyc(6);
    chk_bits("up sda oe", 8'h01, up_oe.sda);
    hold = '0;
    sel = '0;
    cyc(6);
    $display("test stuck auto done");
  endtask

  task automatic t_stuck_noauto;
    auto_dis = 1'b0;
    rel = 5'h1f;
    sel = 4'h1;
    hold = 4'h1;
    falls = 0;
    cyc(150);
    sel = 4'h3;
    cyc(150);
    chk_bits("alarm", 8'h01, alarm_n);
    wait_alarm(1'b0);
    chk_bits("alarm", 8'h00, alarm_n);
    cyc(2000);
    chk_bits("connected", 8'h01, conn);
    chk_cnt("clocks", 0, falls);
    chk_bits("up sda oe", 8'h01, up_oe.sda);
    hold = '0;
    sel = '0;
    cyc(6);
    sel = 4'h2;
    cyc(6);
    chk_bits("alarm", 8'h01, alarm_n);
    sel = '0;
    $display("test stuck manual done");
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    $display("[FAIL] run length expected end seen timeout");
    test_done;
  end

  // Reset spans enough link edges for the link side
  initial begin
    cyc(40);
    sys_rst_i = 1'b0;
    cyc(1);
    t_reset;
    t_accel;
    t_pass;
    t_stuck_auto(5'h03);
    t_stuck_auto(5'h1f);
    t_stuck_noauto;
    test_done;
  end
endmodule // imsbr_mux_tb
